// ==== design/cmd_fifo.sv ====
`timescale 1ns/1ps
module cmd_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic        push;
  logic        pop;

  // =========================================================================
  // Handshake
  // =========================================================================
  // Full and empty come straight from the count, so neither side is ever told a lie.
  assign in_ready_o  = (s.cnt != FULL_CNT);
  assign out_valid_o = (s.cnt != '0);
  assign out_data_o  = s.mem[s.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointers wrap by index compare so a depth that is not a power of two still works.
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data_i;
      next_s.wp        = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + AW'(1);
    end
    if (pop) begin
      next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + AW'(1);
    end
    next_s.cnt = s.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : cmd_fifo

// ==== design/imu_spi_pkg.sv ====
// Overview of operation
// R1: Pulse the sample-ready output each time new sensor results land in the output registers.
// R2: Misc control bit 0 picks sample-ready polarity; default 1 gives a rising leading edge.
// R3: The host starts collecting on the second edge of each sample-ready pulse.
// R4: Sample-ready may misbehave during startup or reset recovery; host ignores those pulses.
// R5: Output bits carry data only when the previous 16-bit frame was a read request.
// R6: While chip select is high the serial output is released for other devices.
// R7: A single read takes two frames: the request, then the returned contents.
// R8: Read request is a zero direction bit, seven-bit byte address, eight ignored bits.
// R9: Full duplex: a new request arrives while the previous answer shifts out.
// R10: Command word 0x6800 starts a burst; chip select stays low for 176 bits.
// R11: Burst words stream back to back without stalls, at serial clocks up to 1 MHz; the test host runs the burst at 8 MHz.
// R12: Outside scaled sync the burst sends flags, rates, accels, temperature, counter, checksum.
// R13: In scaled sync the burst sends flags, rates, accels, temperature, time tag, checksum.
// R14: The checksum sums every high and low byte of the burst data words, unsigned.
// R15: Registers are 16 bits with separately addressed low and high bytes.
// R16: The host writes a register low byte first, then high byte.
// R17: A write word is direction bit 1, byte address, data byte; that byte is stored.
// R18: After power-up or reset the working SRAM is loaded from nonvolatile memory.
// R19: Serial writes change only the working copy, never the nonvolatile one.
// R20: Global command bit 3 saves every backed register to nonvolatile memory.
// R21: Global command bit 7 triggers a software reset with a full reload.
// R22: A low reset pin resets the device, which then runs reset recovery.
// R23: Link is mode 3, MSB first, 16-bit words, slave, clock at most 2 MHz; the test host clocks the link at 8 MHz.
// R24: The checksum is an unsigned 16-bit sum, carries beyond bit 15 dropped.
// R25: The answer during the burst command frame itself is don't care.
package imu_spi_pkg;

  // ==========================================================================
  // Sizes and timing
  // ==========================================================================
  localparam int          CLK_MHZ       = 200;
  localparam int          DR_PULSE_NS   = 1000;
  localparam int          DR_PULSE_CYC  = (DR_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  DR_PULSE_CNT  = 8'(DR_PULSE_CYC);
  localparam int          MEM_BYTES     = 128;
  localparam int          FIFO_DEPTH    = 4;
  localparam int          RW_BIT        = 15;

  // ==========================================================================
  // Byte addresses
  // ==========================================================================
  localparam logic [6:0]  ADDR_DIAG       = 7'h02;
  localparam logic [6:0]  ADDR_X_RATE     = 7'h06;
  localparam logic [6:0]  ADDR_Y_RATE     = 7'h0A;
  localparam logic [6:0]  ADDR_Z_RATE     = 7'h0E;
  localparam logic [6:0]  ADDR_X_ACCEL    = 7'h12;
  localparam logic [6:0]  ADDR_Y_ACCEL    = 7'h16;
  localparam logic [6:0]  ADDR_Z_ACCEL    = 7'h1A;
  localparam logic [6:0]  ADDR_TEMP       = 7'h1C;
  localparam logic [6:0]  ADDR_TIME_TAG   = 7'h1E;
  localparam logic [6:0]  ADDR_SAMPLE_CNT = 7'h22;
  localparam logic [6:0]  ADDR_FLASH_BASE = 7'h40;
  localparam logic [6:0]  ADDR_FLASH_LAST = 7'h7F;
  localparam logic [6:0]  FILTER_CONTROL  = 7'h5C;
  localparam logic [6:0]  MISC_CONTROL    = 7'h60;
  localparam logic [6:0]  ADDR_BURST      = 7'h68;
  localparam logic [6:0]  GLOBAL_COMMAND  = 7'h6E;

  // ==========================================================================
  // Fields and reset values
  // ==========================================================================
  localparam int          MISC_POL_BIT    = 0;
  localparam int          MISC_SYNC_LSB   = 2;
  localparam logic [2:0]  SYNC_SCALED     = 3'h2;
  localparam int          GLOB_SAVE_BIT   = 3;
  localparam int          GLOB_RESET_BIT  = 7;
  localparam logic [7:0]  MISC_RESET      = 8'h01;
  localparam logic [3:0]  BURST_LAST_WORD = 4'h8;
  localparam logic [3:0]  BURST_CSUM_IDX  = 4'h9;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_RUN  = 2'b01,
    ST_SAVE = 2'b11
  } mode_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } wr_cmd_t;

  typedef struct packed {
    logic [15:0] diag;
    logic [15:0] x_rate;
    logic [15:0] y_rate;
    logic [15:0] z_rate;
    logic [15:0] x_accel;
    logic [15:0] y_accel;
    logic [15:0] z_accel;
    logic [15:0] temp;
    logic [15:0] time_tag;
  } sensor_t;

  typedef struct packed {
    logic       req;
    logic       we;
    logic [6:0] addr;
    logic [7:0] wdata;
  } nvm_cmd_t;

endpackage : imu_spi_pkg

// ==== design/imu_spi_register_access.sv ====
`timescale 1ns/1ps
module imu_spi_register_access (
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  input  wire logic                  rst_pin_n_i,
  input  wire logic                  sclk_i,
  input  wire logic                  cs_n_i,
  input  wire logic                  sdi_i,
  output logic                       sdo_o,
  output logic                       sdo_oe_o,
  input  wire logic                  sensor_valid_i,
  input  wire imu_spi_pkg::sensor_t  sensor_i,
  output logic                       sample_ready_strobe_o,
  output imu_spi_pkg::nvm_cmd_t      nvm_o,
  input  wire logic [7:0]            nvm_rdata_i,
  input  wire logic                  nvm_ack_i
);
  import imu_spi_pkg::*;

  // =========================================================================
  // State
  // =========================================================================
  typedef struct packed {
    mode_t                     st;
    logic [MEM_BYTES-1:0][7:0] mem;
    nvm_cmd_t                  nvm;
    logic [2:0]                sclk_sy;
    logic [2:0]                cs_sy;
    logic [2:0]                sdi_sy;
    logic [2:0]                rst_sy;
    logic                      sclk_lv;
    logic                      cs_lv;
    logic                      sdi_lv;
    logic                      rst_lv;
    logic [3:0]                bitcnt;
    logic [15:0]               rx;
    logic [15:0]               tx;
    logic                      sdo;
    logic                      oe;
    logic                      burst_on;
    logic [3:0]                burst_idx;
    logic [15:0]               csum;
    logic [15:0]               sample_cnt;
    logic [7:0]                pulse_cnt;
    logic                      dr;
  } state_t;

  // The misc byte starts with the documented polarity so the strobe idles correctly before the load.
  localparam logic [MEM_BYTES-1:0][7:0] MEM_RESET = (MEM_BYTES * 8)'(MISC_RESET) << (32'(MISC_CONTROL) * 8);
  localparam state_t STATE_RESET = '{
    st: ST_LOAD, mem: MEM_RESET, nvm: '{req: 1'b0, we: 1'b0, addr: ADDR_FLASH_BASE, wdata: 8'h00},
    sclk_sy: 3'h7, cs_sy: 3'h7, sdi_sy: 3'h0, rst_sy: 3'h7,
    sclk_lv: 1'b1, cs_lv: 1'b1, sdi_lv: 1'b0, rst_lv: 1'b1,
    bitcnt: 4'h0, rx: 16'h0000, tx: 16'h0000, sdo: 1'b0, oe: 1'b0,
    burst_on: 1'b0, burst_idx: 4'h0, csum: 16'h0000, sample_cnt: 16'h0000,
    pulse_cnt: 8'h00, dr: 1'b0
  };

  state_t  s;
  state_t  next_s;
  logic    push_valid;
  logic    push_ready;
  wr_cmd_t push_data;
  logic    pop_valid;
  logic    pop_ready;
  wr_cmd_t pop_data;

  // =========================================================================
  // Helpers
  // =========================================================================
  // Both byte addresses of a register select the same word.
  function automatic logic [15:0] read_word(input logic [MEM_BYTES-1:0][7:0] m, input logic [6:0] a);
    logic [6:0] base;
    base = {a[6:1], 1'b0};
    return {m[base | 7'h01], m[base]};
  endfunction : read_word

  function automatic logic [15:0] byte_sum(input logic [15:0] w);
    return 16'(w[15:8]) + 16'(w[7:0]);
  endfunction : byte_sum

  // Burst order; the last data word depends on the sync mode.
  function automatic logic [6:0] burst_addr(input logic [3:0] idx, input logic scaled);
    logic [6:0] a;
    a = ADDR_DIAG;
    case (idx)
      4'h0:    a = ADDR_DIAG;
      4'h1:    a = ADDR_X_RATE;
      4'h2:    a = ADDR_Y_RATE;
      4'h3:    a = ADDR_Z_RATE;
      4'h4:    a = ADDR_X_ACCEL;
      4'h5:    a = ADDR_Y_ACCEL;
      4'h6:    a = ADDR_Z_ACCEL;
      4'h7:    a = ADDR_TEMP;
      4'h8:    a = scaled ? ADDR_TIME_TAG : ADDR_SAMPLE_CNT; // [R12] [R13]
      default: a = ADDR_DIAG;
    endcase
    return a;
  endfunction : burst_addr

  // Puts one 16-bit word into the image at its even byte address, low byte first.
  function automatic logic [MEM_BYTES-1:0][7:0] put_word(input logic [MEM_BYTES-1:0][7:0] m,
                                                          input logic [6:0] a, input logic [15:0] w);
    logic [MEM_BYTES-1:0][7:0] r;
    r           = m;
    r[a]        = w[7:0];
    r[a | 7'h01] = w[15:8];
    return r;
  endfunction : put_word

  // =========================================================================
  // Write queue
  // =========================================================================
  // Writes wait here while a nonvolatile save or reload owns the image.
  cmd_fifo #(
    .WIDTH ($bits(wr_cmd_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_cmd_fifo (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_data),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_data)
  );

  assign pop_ready = (s.st == ST_RUN);

  // =========================================================================
  // Next state
  // =========================================================================
  always_comb begin
    logic        rise;
    logic        fall;
    logic        sel;
    logic        scaled;
    logic        pol;
    logic        dr_act;
    logic [15:0] w;
    logic [15:0] wv;
    logic [6:0]  a;
    rise       = 1'b0;
    fall       = 1'b0;
    sel        = 1'b0;
    scaled     = 1'b0;
    pol        = 1'b0;
    dr_act     = 1'b0;
    w          = 16'h0000;
    wv         = 16'h0000;
    a          = 7'h00;
    next_s     = s;
    push_valid = 1'b0;
    push_data  = '0;

    // Three-stage sampling; a level counts only once the second and third stages agree.
    next_s.sclk_sy = {s.sclk_sy[1:0], sclk_i};
    next_s.cs_sy   = {s.cs_sy[1:0], cs_n_i};
    next_s.sdi_sy  = {s.sdi_sy[1:0], sdi_i};
    next_s.rst_sy  = {s.rst_sy[1:0], rst_pin_n_i};
    if (s.sclk_sy[1] == s.sclk_sy[2]) next_s.sclk_lv = s.sclk_sy[2];
    if (s.cs_sy[1] == s.cs_sy[2]) next_s.cs_lv = s.cs_sy[2];
    if (s.sdi_sy[1] == s.sdi_sy[2]) next_s.sdi_lv = s.sdi_sy[2];
    if (s.rst_sy[1] == s.rst_sy[2]) next_s.rst_lv = s.rst_sy[2];
    rise   = next_s.sclk_lv & ~s.sclk_lv;
    fall   = ~next_s.sclk_lv & s.sclk_lv;
    sel    = ~next_s.cs_lv;
    scaled = (s.mem[MISC_CONTROL][MISC_SYNC_LSB +: 3] == SYNC_SCALED);
    pol    = s.mem[MISC_CONTROL][MISC_POL_BIT];

    // Serial engine: mode 3, change on falling edge, sample on rising edge. [R23]
    next_s.oe = sel; // [R6]
    if (!sel) begin
      next_s.bitcnt   = 4'h0;
      next_s.burst_on = 1'b0; // [R10]
    end else begin
      if (fall) begin
        next_s.sdo = s.tx[15];
        next_s.tx  = {s.tx[14:0], 1'b0};
      end
      if (rise) begin
        w             = {s.rx[14:0], next_s.sdi_lv};
        next_s.rx     = w;
        next_s.bitcnt = s.bitcnt + 4'h1;
        if (s.bitcnt == 4'hF) begin
          // Frame boundary: the answer for the next frame is loaded here, so no gap opens. [R9] [R11]
          if (s.burst_on && s.burst_idx <= BURST_LAST_WORD) begin
            wv               = read_word(s.mem, burst_addr(s.burst_idx, scaled));
            next_s.tx        = wv;
            next_s.csum      = s.csum + byte_sum(wv); // [R14] [R24]
            next_s.burst_idx = s.burst_idx + 4'h1;
          end else if (s.burst_on) begin
            next_s.tx       = s.csum; // [R24]
            next_s.burst_on = 1'b0;
          end else if (!w[RW_BIT]) begin
            a = w[14:8];
            if (a == ADDR_BURST && s.st == ST_RUN) begin
              // The answer already shifting in this frame is left as is. [R25] [R10]
              wv               = read_word(s.mem, burst_addr(4'h0, scaled));
              next_s.tx        = wv;
              next_s.csum      = byte_sum(wv); // [R14]
              next_s.burst_idx = 4'h1;
              next_s.burst_on  = 1'b1;
            end else begin
              next_s.tx = read_word(s.mem, a); // [R7] [R8]
            end
          end else begin
            // A write returns zeros in the following frame. [R5]
            next_s.tx      = 16'h0000;
            push_valid     = 1'b1; // [R17]
            push_data.addr = w[14:8];
            push_data.data = w[7:0];
          end
        end
      end
    end

    // Queued writes only reach the working image, never the backing store. [R15] [R19]
    if (pop_valid && pop_ready && pop_data.addr >= ADDR_FLASH_BASE) begin
      if (pop_data.addr == GLOBAL_COMMAND) begin
        if (pop_data.data[GLOB_RESET_BIT]) begin
          next_s.st       = ST_LOAD; // [R21]
          next_s.nvm.addr = ADDR_FLASH_BASE;
        end else if (pop_data.data[GLOB_SAVE_BIT]) begin
          next_s.st       = ST_SAVE; // [R20]
          next_s.nvm.addr = ADDR_FLASH_BASE;
        end
      end else begin
        next_s.mem[pop_data.addr] = pop_data.data; // [R16] [R17]
      end
    end

    // Fresh sensor results refresh the output words and fire the strobe. [R1]
    if (sensor_valid_i && s.st == ST_RUN) begin
      next_s.sample_cnt = s.sample_cnt + 16'h0001;
      next_s.mem        = put_word(next_s.mem, ADDR_DIAG, sensor_i.diag);
      next_s.mem        = put_word(next_s.mem, ADDR_X_RATE, sensor_i.x_rate);
      next_s.mem        = put_word(next_s.mem, ADDR_Y_RATE, sensor_i.y_rate);
      next_s.mem        = put_word(next_s.mem, ADDR_Z_RATE, sensor_i.z_rate);
      next_s.mem        = put_word(next_s.mem, ADDR_X_ACCEL, sensor_i.x_accel);
      next_s.mem        = put_word(next_s.mem, ADDR_Y_ACCEL, sensor_i.y_accel);
      next_s.mem        = put_word(next_s.mem, ADDR_Z_ACCEL, sensor_i.z_accel);
      next_s.mem        = put_word(next_s.mem, ADDR_TEMP, sensor_i.temp);
      next_s.mem        = put_word(next_s.mem, ADDR_TIME_TAG, sensor_i.time_tag);
      next_s.mem        = put_word(next_s.mem, ADDR_SAMPLE_CNT, next_s.sample_cnt);
      next_s.pulse_cnt  = DR_PULSE_CNT; // [R1]
    end else if (s.pulse_cnt != 8'h00) begin
      next_s.pulse_cnt = s.pulse_cnt - 8'h01;
    end

    // Nonvolatile sequencer: one byte per acknowledged request over the backed range.
    next_s.nvm.req = 1'b0;
    case (s.st)
      ST_LOAD: begin
        next_s.nvm.we  = 1'b0;
        next_s.nvm.req = ~(s.nvm.req & nvm_ack_i);
        if (s.nvm.req && nvm_ack_i) begin
          next_s.mem[s.nvm.addr] = nvm_rdata_i; // [R18]
          if (s.nvm.addr == ADDR_FLASH_LAST) begin
            next_s.st      = ST_RUN;
            next_s.nvm.req = 1'b0;
          end else begin
            next_s.nvm.addr = s.nvm.addr + 7'h01;
          end
        end
      end
      ST_SAVE: begin
        next_s.nvm.we    = 1'b1;
        next_s.nvm.wdata = s.mem[s.nvm.addr]; // [R20]
        next_s.nvm.req   = ~(s.nvm.req & nvm_ack_i);
        if (s.nvm.req && nvm_ack_i) begin
          if (s.nvm.addr == ADDR_FLASH_LAST) begin
            next_s.st      = ST_RUN;
            next_s.nvm.req = 1'b0;
            next_s.nvm.we  = 1'b0;
          end else begin
            next_s.nvm.addr  = s.nvm.addr + 7'h01;
            next_s.nvm.wdata = s.mem[s.nvm.addr + 7'h01];
          end
        end
      end
      ST_RUN: begin
        next_s.nvm.we = 1'b0;
      end
      default: begin
        next_s.st = ST_LOAD;
      end
    endcase

    // A held reset pin parks the device in recovery; the reload starts on release. [R22]
    if (!next_s.rst_lv) begin
      next_s.st        = ST_LOAD;
      next_s.nvm.req   = 1'b0;
      next_s.nvm.we    = 1'b0;
      next_s.nvm.addr  = ADDR_FLASH_BASE;
      next_s.pulse_cnt = 8'h00;
      next_s.burst_on  = 1'b0;
    end

    // Polarity bit set means the strobe is high while active; no pulses while recovering. [R2] [R4]
    dr_act    = (next_s.pulse_cnt != 8'h00);
    next_s.dr = dr_act ? pol : ~pol; // [R2]
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // =========================================================================
  // Outputs
  // =========================================================================
  assign sdo_o                 = s.sdo;
  assign sdo_oe_o              = s.oe;  // [R6]
  assign sample_ready_strobe_o = s.dr;  // [R1]
  assign nvm_o                 = s.nvm;
endmodule : imu_spi_register_access

// ==== tb/imu_spi_checker.sv ====
`timescale 1ns/1ps
module imu_spi_checker (
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  input  wire logic                  cs_n_i,
  input  wire logic                  sclk_i,
  input  wire logic                  sdo_o,
  input  wire logic                  sdo_oe_o,
  input  wire logic                  sensor_valid_i,
  input  wire logic                  sample_ready_strobe_o,
  input  wire imu_spi_pkg::nvm_cmd_t nvm_o,
  input  wire logic                  nvm_ack_i
);
  import imu_spi_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ====================
  // Strobe age
  // ====================
  // Cycles since the last sensor update, so pulse width is judged whatever the polarity.
  logic [7:0] age;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      age <= 8'h00;
    end else if (sensor_valid_i) begin
      age <= 8'h01;
    end else if (age != 8'h00 && age < 8'hC9) begin
      age <= age + 8'h01;
    end else begin
      age <= 8'h00;
    end
  end
  // ====================
  // Properties
  // ====================
  a_strobe_starts: assert property (age == 8'h01 && $past(age) == 8'h00 |-> $changed(sample_ready_strobe_o))
    else $error("strobe did not start after sensor update");
  a_strobe_holds: assert property (age > 8'h01 && age <= 8'hC8 |-> $stable(sample_ready_strobe_o))
    else $error("strobe moved inside its pulse");
  a_strobe_ends: assert property (age == 8'hC8 |=> $changed(sample_ready_strobe_o))
    else $error("strobe pulse width wrong");
  a_out_released: assert property (cs_n_i [*6] |-> !sdo_oe_o)
    else $error("serial output driven while deselected");
  a_out_driven: assert property (!cs_n_i [*6] |-> sdo_oe_o)
    else $error("serial output not driven while selected");
  a_data_holds: assert property ((sclk_i && !cs_n_i) [*8] |-> $stable(sdo_o))
    else $error("serial output changed while clock high");
  a_nvm_req_holds: assert property (nvm_o.req && !nvm_ack_i |=> nvm_o.req && $stable(nvm_o))
    else $error("memory request dropped before acknowledge");
  a_load_begins: assert property ($rose(nrst_i) |-> ##[1:3] (nvm_o.req && !nvm_o.we && nvm_o.addr == ADDR_FLASH_BASE))
    else $error("reload did not start at first backed byte");
  a_nvm_in_range: assert property (nvm_o.req |-> nvm_o.addr >= ADDR_FLASH_BASE)
    else $error("memory access outside backed range");
  c_save_write: cover property (nvm_o.req && nvm_o.we && nvm_ack_i);
  c_pulse_end: cover property (age == 8'hC8);
  c_select: cover property ($fell(cs_n_i));
endmodule : imu_spi_checker

bind imu_spi_register_access imu_spi_checker imu_spi_checker_inst (.clk_i(clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i),
  .sclk_i(sclk_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .sensor_valid_i(sensor_valid_i),
  .sample_ready_strobe_o(sample_ready_strobe_o), .nvm_o(nvm_o), .nvm_ack_i(nvm_ack_i));

// ==== tb/spi_host_model.sv ====
`timescale 1ns/1ps
module spi_host_model (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o,
  input  wire logic miso_i
);
  // ====================
  // Mode 3 master
  // ====================
  // The clock idles high and stands still between frames.
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // A 1 ns skew on select keeps every link edge clear of clk_i edges.
  task automatic sel(input logic on);
    #(100 + on);
    cs_n_o = !on;
    if (!on) begin
      sdi_o = !sdi_o;
    end
    #(99 + on);
  endtask : sel
  // Drive on the falling edge, sample on the rising edge, MSB first, no gaps.
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    for (int i = 15; i >= 0; i--) begin
      #62.5 sclk_o = 1'b0;
      sdi_o = tx[i];
      #62.5 sclk_o = 1'b1;
      rx[i] = miso_i;
    end
  endtask : frame
endmodule : spi_host_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import imu_spi_pkg::*;
  logic       clk_i, nrst_i, rst_pin_n_i, sensor_valid_i, nvm_ack_i;
  logic       sclk, cs_n, sdi, sdo_o, sdo_oe_o, strobe;
  logic [7:0] nvm_rdata_i;
  sensor_t    s;
  nvm_cmd_t   nvm;
  logic [7:0] flash [128];
  logic [7:0] img [128];
  int         seed, mismatches, n_checks, nld, nsv;
  wire        miso = sdo_oe_o ? sdo_o : 1'bz;
  imu_spi_register_access imu_spi_register_access_inst (.clk_i(clk_i), .nrst_i(nrst_i), .rst_pin_n_i(rst_pin_n_i),
    .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .sensor_valid_i(sensor_valid_i),
    .sensor_i(s), .sample_ready_strobe_o(strobe), .nvm_o(nvm), .nvm_rdata_i(nvm_rdata_i), .nvm_ack_i(nvm_ack_i));
  spi_host_model spi_host_model_inst (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .miso_i(miso));
  // ====================
  // Clock, flash, watchdog
  // ====================
  // Clock at 200 MHz.
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = !clk_i;
  end
  // Flash answers each request one cycle later; a save byte lands with its acknowledge.
  always @(posedge clk_i) begin
    nvm_ack_i <= nvm.req && !nvm_ack_i;
    nvm_rdata_i <= flash[nvm.addr];
    if (nvm.req && !nvm_ack_i && nvm.we) begin
      flash[nvm.addr] <= nvm.wdata;
      nsv <= nsv + 1;
    end else if (nvm.req && !nvm_ack_i) begin
      nld <= nld + 1;
    end
  end
  // The whole run needs about 140 us, so a hang is cut off well past that.
  initial begin
    #400us;
    mismatches++;
    conclude();
  end
  // ====================
  // Tasks
  // ====================
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic xf(input logic [15:0] tx, output logic [15:0] rx);
    spi_host_model_inst.sel(1'b1);
    spi_host_model_inst.frame(tx, rx);
    spi_host_model_inst.sel(1'b0);
  endtask : xf
  task automatic rd(input logic [6:0] a, output logic [15:0] r);
    logic [15:0] j;
    xf({1'b0, a, 8'h00}, j);
    xf(16'h0000, r);
  endtask : rd
  task automatic ww(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] j;
    xf({1'b1, a, d}, j);
  endtask : ww
  task automatic wt(input bit sv);
    for (int t = 0; t < 4000 && (sv ? nsv : nld) < 64; t++) @(posedge clk_i);
    chk("memory bytes", 16'h0040, 16'(sv ? nsv : nld));
  endtask : wt
  function automatic logic [15:0] csum(input logic [143:0] w);
    logic [15:0] acc;
    acc = 16'h0000;
    for (int i = 0; i < 18; i++) acc += 16'(w[i*8 +: 8]);
    return acc;
  endfunction : csum
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  // ====================
  // Main sequence
  // ====================
  // Misc control loads as 0x01 so the strobe starts active high.
  initial begin
    logic [15:0]  r, c0;
    logic [6:0]   a;
    logic [7:0]   d, m;
    logic [143:0] e9;
    seed = 48451;
    {mismatches, n_checks, nld, nsv} = '0;
    {nrst_i, sensor_valid_i, nvm_ack_i, nvm_rdata_i, s} = '0;
    rst_pin_n_i = 1'b1;
    for (int i = 0; i < 128; i++) flash[i] = (i == 96) ? 8'h01 : (i == 110) ? 8'h00 : 8'($random(seed));
    img = flash;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    wt(1'b0);
    for (int i = 0; i < 6; i++) begin
      a = 7'h40 + 7'($random(seed) & 31);
      d = 8'($random(seed));
      ww(a, d);
      img[a] = d;
      rd(a, r);
      chk("reg read", {img[a | 7'h01], img[a & 7'h7E]}, r);
    end
    ww(FILTER_CONTROL, 8'h04);
    ww(FILTER_CONTROL + 7'h01, 8'h00);
    {img[93], img[92]} = 16'h0004;
    rd(FILTER_CONTROL + 7'h01, r);
    chk("filter", 16'h0004, r);
    chk("no save", 16'h0000, 16'(nsv));
    ww(GLOBAL_COMMAND, 8'h08);
    wt(1'b1);
    for (int i = 64; i < 96; i += 2) chk("saved", {img[i+1], img[i]}, {flash[i+1], flash[i]});
    for (int k = 0; k < 2; k++) begin
      ww(FILTER_CONTROL, 8'hAA);
      nld = 0;
      if (k == 0) begin
        ww(GLOBAL_COMMAND, 8'h80);
      end else begin
        @(posedge clk_i);
        rst_pin_n_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rst_pin_n_i <= 1'b1;
      end
      wt(1'b0);
      rd(FILTER_CONTROL, r);
      chk("reload", 16'h0004, r);
    end
    for (int k = 0; k < 2; k++) begin
      m = k ? 8'h08 : 8'h01;
      ww(MISC_CONTROL, m);
      chk("idle", 16'(!m[0]), 16'(strobe));
      rd(ADDR_SAMPLE_CNT, c0);
      @(posedge clk_i);
      for (int j = 0; j < 9; j++) s[j*16 +: 16] <= 16'($random(seed));
      sensor_valid_i <= 1'b1;
      @(posedge clk_i);
      sensor_valid_i <= 1'b0;
      #1;
      chk("active", 16'(m[0]), 16'(strobe));
      repeat (199) @(posedge clk_i);
      #1;
      chk("active", 16'(m[0]), 16'(strobe));
      @(posedge clk_i);
      #1;
      chk("idle", 16'(!m[0]), 16'(strobe));
      e9 = {s[143:16], (m[4:2] == SYNC_SCALED) ? s.time_tag : c0 + 16'h0001};
      spi_host_model_inst.sel(1'b1);
      spi_host_model_inst.frame(16'h6800, r);
      for (int j = 0; j < 10; j++) begin
        spi_host_model_inst.frame(16'h0000, r);
        chk("burst", (j < 9) ? e9[143-16*j -: 16] : csum(e9), r);
      end
      spi_host_model_inst.sel(1'b0);
    end
    conclude();
  end
endmodule : tb_top
